/* File: sfx_defines.svh */
`ifndef SFX_DEFINES_SVH
`define SFX_DEFINES_SVH

// ------------------------------------------------------------
// Opcode decode
// ------------------------------------------------------------
`define SFX_OP_ENTER      8'h0f     // Upper byte of frame-building opcode
`define SFX_OP_BYTE_SWAP  8'h8a     // Upper byte of byte_swap_instr opcode
`define SFX_OP_LEAVE      16'h9f9f  // Whole frame-releasing opcode

// ------------------------------------------------------------
// Register numbers and offsets
// ------------------------------------------------------------
`define SFX_FP_IDX        4'hf - 4'h1  // frame_pointer_reg number
`define SFX_SP_IDX        4'hf         // stack_pointer_reg number
`define SFX_WORD_OFS      32'h0000_0004 // Frame link slot offset
`define SFX_FRAME_SHIFT   2            // Scaled field to byte count

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define SFX_GPR_RST       32'h0000_0000
`define SFX_FLAGS_RST     4'h0

// ------------------------------------------------------------
// Extension modes and widths
// ------------------------------------------------------------
`define SFX_EXT_ZERO      2'h0
`define SFX_EXT_ONES      2'h1
`define SFX_EXT_SIGN      2'h2
`define SFX_W4            2'h0
`define SFX_W8            2'h1
`define SFX_W10           2'h2
`define SFX_W16           2'h3

`endif

/* File: sfx_pkg.sv */
package sfx_pkg;

  // ------------------------------------------------------------
  // Execution states, one-hot
  // ------------------------------------------------------------
  typedef enum logic [6:0] {
    SFX_IDLE   = 7'b0000001,  // Waiting for an instruction
    SFX_ENT_WR = 7'b0000010,  // Frame link store
    SFX_LEV_RD = 7'b0000100,  // Frame link reload
    SFX_XCH_RD = 7'b0001000,  // Swap read half
    SFX_XCH_WR = 7'b0010000,  // Swap write half
    SFX_ILOCK  = 7'b0100000,  // One inserted interlock cycle
    SFX_SPARE  = 7'b1000000   // Never entered
  } sfx_state_t;

  // ------------------------------------------------------------
  // Whole module state
  // ------------------------------------------------------------
  typedef struct packed {
    sfx_state_t        st;        // Sequencer
    logic [15:0][31:0] gpr;       // General-purpose registers
    logic [31:0]       tmp;       // Scratch latch for swap
    logic [3:0]        dst;       // Swap destination number
    logic [3:0]        flags;     // N Z V C
    logic              mem_req;   // Access in progress
    logic              mem_we;    // Write access
    logic              mem_byte;  // Byte-wide access
    logic [31:0]       mem_addr;  // Access address
    logic [31:0]       mem_wdata; // Store data
    logic              busy;      // Instruction in flight
    logic              ready;     // May take an instruction
    logic              done;      // Completion pulse
    logic              ilock;     // Interlock cycle marker
    logic              hold_ack;  // Bus handed to external master
    logic [31:0]       ext_res;   // Extension unit result
    logic [31:0]       rd_data;   // Register peek result
  } sfx_reg_t;

endpackage

/* File: sfx_exec.sv */
`timescale 1ns/10ps
`include "sfx_defines.svh"

// Behaviour
// RULE1: Frame build stores FP, FP=SP-4, SP-=imm*4
// RULE2: Frame size field is size divided by four
// RULE3: Frame build: one cycle plus access period
// RULE4: Three instructions never touch NZVC flags
// RULE5: Frame release: SP=FP+4, FP reloaded
// RULE6: Frame release: one load access, interlocked
// RULE7: Swap stores low byte of destination
// RULE8: Read byte zero-extended into destination
// RULE9: No bus hold between swap halves
// RULE10: Swap is one read then one write
// RULE11: Access periods stretch while ready low
// RULE12: Load-use adds one cycle
// RULE13: Stack pointer interlock adds one cycle
// RULE14: Zero extension fills upper bits with 0
// RULE15: Ones extension fills upper bits with 1
// RULE16: Sign extension follows operand top bit
// RULE17: Sixteen registers, fifteen is stack pointer
// RULE18: Frame build opcode upper byte 0x0f
// RULE19: Swap opcode 0x8a, source then destination
module sfx_exec #(
  parameter int GPRS = 16  // Register file depth
) (
  input  wire logic        core_clk_in,       // Core clock
  input  wire logic        srst_in,           // Synchronous reset
  input  wire logic        clk_en_in,         // Freezes all state when low
  input  wire logic        instr_valid_in,    // Instruction offered
  input  wire logic [15:0] instr_in,          // Instruction word
  input  wire logic [15:0] next_reads_gpr_in, // Registers next instruction reads
  input  wire logic        next_sp_access_in, // Next touches any stack pointer
  input  wire logic        next_type_a_in,    // Next is two-register format
  input  wire logic        mem_ready_in,      // Access completes this cycle
  input  wire logic [31:0] mem_rdata_in,      // Read data, byte in low lane
  input  wire logic        hold_req_in,       // External bus hold request
  input  wire logic        gpr_wr_en_in,      // Preload a register
  input  wire logic [3:0]  gpr_wr_idx_in,     // Preload register number
  input  wire logic [31:0] gpr_wr_data_in,    // Preload value
  input  wire logic [3:0]  gpr_rd_idx_in,     // Peek register number
  input  wire logic        flags_wr_en_in,    // Write NZVC from outside
  input  wire logic [3:0]  flags_in,          // New NZVC
  input  wire logic [15:0] ext_val_in,        // Extension operand
  input  wire logic [1:0]  ext_width_in,      // Operand width code
  input  wire logic [1:0]  ext_mode_in,       // Zero, ones or sign
  output logic             instr_ready_out,   // Instruction will be taken
  output logic             busy_out,          // Instruction in flight
  output logic             done_out,          // One-cycle completion
  output logic             ilock_out,         // Interlock cycle running
  output logic             mem_req_out,       // Access request
  output logic             mem_we_out,        // Write access
  output logic             mem_byte_out,      // Byte-wide access
  output logic [31:0]      mem_addr_out,      // Access address
  output logic [31:0]      mem_wdata_out,     // Store data
  output logic             hold_ack_out,      // Bus handed over
  output logic [31:0]      sp_out,            // Stack pointer value
  output logic [31:0]      fp_out,            // Frame pointer value
  output logic [31:0]      gpr_rd_data_out,   // Peek result
  output logic [3:0]       flags_out,         // NZVC
  output logic [31:0]      ext_res_out        // Extension result
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------

  // Width code to operand bit count
  function automatic int unsigned ext_bits(input logic [1:0] w);
    case (w)
      `SFX_W4:  ext_bits = 4;
      `SFX_W8:  ext_bits = 8;
      `SFX_W10: ext_bits = 10;
      default:  ext_bits = 16;
    endcase
  endfunction

  // Widen a narrow operand to a word
  function automatic logic [31:0] extend(input logic [15:0] v,
                                         input logic [1:0]  w,
                                         input logic [1:0]  mode);
    int unsigned n;
    logic        fill;
    logic [31:0] r;
    n    = ext_bits(w);
    fill = 1'b0;
    case (mode)
      `SFX_EXT_ONES: fill = 1'b1;                // RULE15
      `SFX_EXT_SIGN: fill = v[n - 1];            // RULE16
      default:       fill = 1'b0;                // RULE14
    endcase
    r = {32{fill}};
    for (int i = 0; i < 16; i++)
    begin
      if (i < n)
      begin
        r[i] = v[i];
      end
    end
    extend = r;
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  sfx_pkg::sfx_reg_t q_q;  // Registered state
  sfx_pkg::sfx_reg_t q_d;  // Next state

  // Frame size in bytes; field is size over four, so 0..1020
  logic [31:0] frame_bytes;
  assign frame_bytes = extend({6'h00, instr_in[7:0], 2'h0},  // RULE2
                              `SFX_W10, `SFX_EXT_ZERO);

  // Opcode classes
  logic is_enter;
  logic is_leave;
  logic is_swap;
  assign is_enter = instr_in[15:8] == `SFX_OP_ENTER;         // RULE18
  assign is_leave = instr_in == `SFX_OP_LEAVE;
  assign is_swap  = instr_in[15:8] == `SFX_OP_BYTE_SWAP;     // RULE19

  // Register fields of the swap: source high nibble, destination low
  logic [3:0] src_gpr;
  logic [3:0] dest_gpr;
  assign src_gpr  = instr_in[7:4];                           // RULE19
  assign dest_gpr = instr_in[3:0];                           // RULE19

  // Convenience views of the pointers
  logic [31:0] stack_pointer_reg;
  logic [31:0] frame_pointer_reg;
  assign stack_pointer_reg = q_q.gpr[`SFX_SP_IDX];           // RULE17
  assign frame_pointer_reg = q_q.gpr[`SFX_FP_IDX];

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb
  begin
    logic [31:0] link;
    logic [31:0] new_sp;
    logic        fin;
    logic        stall;
    link   = '0;
    new_sp = '0;
    fin    = 1'b0;
    stall  = 1'b0;
    q_d      = q_q;
    q_d.done = 1'b0;
    q_d.ilock = 1'b0;

    // Flags only move by the outside write port
    if (flags_wr_en_in)                                      // RULE4
    begin
      q_d.flags = flags_in;
    end

    // Free-standing extension unit
    q_d.ext_res = extend(ext_val_in, ext_width_in, ext_mode_in);

    case (q_q.st)
      sfx_pkg::SFX_IDLE:
      begin
        // Preload only while idle so it never races the sequencer
        if (gpr_wr_en_in)
        begin
          q_d.gpr[gpr_wr_idx_in] = gpr_wr_data_in;
        end
        if (instr_valid_in && q_q.ready)
        begin
          if (is_enter)
          begin
            // Link slot one word below SP; this cycle is the "1"
            link          = stack_pointer_reg - `SFX_WORD_OFS;
            q_d.mem_addr  = link;                            // RULE1
            q_d.mem_wdata = frame_pointer_reg;               // RULE1
            q_d.mem_we    = 1'b1;
            q_d.mem_byte  = 1'b0;
            q_d.mem_req   = 1'b1;                            // RULE3
            q_d.gpr[`SFX_FP_IDX] = link;                     // RULE1
            q_d.gpr[`SFX_SP_IDX] = stack_pointer_reg - frame_bytes; // RULE1
            q_d.st        = sfx_pkg::SFX_ENT_WR;
          end
          else if (is_leave)
          begin
            // SP first, then the link reloads from just below it
            new_sp        = frame_pointer_reg + `SFX_WORD_OFS;
            q_d.gpr[`SFX_SP_IDX] = new_sp;                   // RULE5
            q_d.mem_addr  = new_sp - `SFX_WORD_OFS;          // RULE5
            q_d.mem_we    = 1'b0;
            q_d.mem_byte  = 1'b0;
            q_d.mem_req   = 1'b1;                            // RULE6
            q_d.st        = sfx_pkg::SFX_LEV_RD;
          end
          else if (is_swap)
          begin
            // Old destination parked until the write half
            q_d.tmp       = q_q.gpr[dest_gpr];               // RULE7
            q_d.dst       = dest_gpr;
            q_d.mem_addr  = q_q.gpr[src_gpr];                // RULE7
            q_d.mem_we    = 1'b0;
            q_d.mem_byte  = 1'b1;
            q_d.mem_req   = 1'b1;                            // RULE10
            q_d.st        = sfx_pkg::SFX_XCH_RD;
          end
          else
          begin
            // Not ours: dropped without effect
            q_d.st = sfx_pkg::SFX_IDLE;
          end
        end
      end

      sfx_pkg::SFX_ENT_WR:
      begin
        // Period lasts until the memory side stops holding off
        if (mem_ready_in)                                    // RULE11
        begin
          q_d.mem_req = 1'b0;
          q_d.mem_we  = 1'b0;
          fin         = 1'b1;
          // Frame build moved SP, so SP users must wait
          stall = next_sp_access_in || next_type_a_in;       // RULE13
        end
      end

      sfx_pkg::SFX_LEV_RD:
      begin
        if (mem_ready_in)                                    // RULE11
        begin
          q_d.gpr[`SFX_FP_IDX] = mem_rdata_in;               // RULE5
          q_d.mem_req = 1'b0;
          fin         = 1'b1;
          stall = next_reads_gpr_in[`SFX_FP_IDX];            // RULE6 RULE12
        end
      end

      sfx_pkg::SFX_XCH_RD:
      begin
        if (mem_ready_in)                                    // RULE11
        begin
          // Read half done; write half follows with no gap
          q_d.gpr[q_q.dst] = extend({8'h00, mem_rdata_in[7:0]},
                                    `SFX_W8, `SFX_EXT_ZERO); // RULE8
          q_d.mem_we    = 1'b1;                              // RULE10
          q_d.mem_wdata = {24'h000000, q_q.tmp[7:0]};        // RULE7
          q_d.st        = sfx_pkg::SFX_XCH_WR;
        end
      end

      sfx_pkg::SFX_XCH_WR:
      begin
        if (mem_ready_in)                                    // RULE11
        begin
          // Byte lane flag dropped so a stale byte access never leaks
          q_d.mem_req  = 1'b0;
          q_d.mem_we   = 1'b0;
          q_d.mem_byte = 1'b0;
          fin          = 1'b1;
          // Destination was loaded, so a reader must wait
          stall = next_reads_gpr_in[q_q.dst];                // RULE12
        end
      end

      sfx_pkg::SFX_ILOCK:
      begin
        // Single inserted cycle, then report completion
        q_d.done = 1'b1;
        q_d.st   = sfx_pkg::SFX_IDLE;
      end

      default:
      begin
        q_d.st = sfx_pkg::SFX_IDLE;
      end
    endcase

    // Common finish: straight to idle or via one interlock cycle
    if (fin)
    begin
      if (stall)
      begin
        q_d.ilock = 1'b1;                                    // RULE12
        q_d.st    = sfx_pkg::SFX_ILOCK;
      end
      else
      begin
        q_d.done = 1'b1;
        q_d.st   = sfx_pkg::SFX_IDLE;
      end
    end

    // Hold granted only when idle, so a swap is never split
    // Trade-off: hold waits for the whole instruction, not only the swap
    // halves; a little bus latency is spent to keep one simple rule
    q_d.hold_ack = hold_req_in && (q_d.st == sfx_pkg::SFX_IDLE); // RULE9
    q_d.busy     = q_d.st != sfx_pkg::SFX_IDLE;
    q_d.ready    = (q_d.st == sfx_pkg::SFX_IDLE) && !q_d.hold_ack;

    // Peek port reads the settled file
    q_d.rd_data = q_d.gpr[gpr_rd_idx_in];
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      // Reset beats the clock enable, so a frozen core still clears
      q_q       <= '0;
      q_q.st    <= sfx_pkg::SFX_IDLE;
      q_q.gpr   <= {GPRS{`SFX_GPR_RST}};
      q_q.flags <= `SFX_FLAGS_RST;
      q_q.ready <= 1'b1;
    end
    else if (clk_en_in)
    begin
      q_q <= q_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs, all straight from the state register
  // ------------------------------------------------------------
  assign instr_ready_out = q_q.ready;
  assign busy_out        = q_q.busy;
  assign done_out        = q_q.done;
  assign ilock_out       = q_q.ilock;
  assign mem_req_out     = q_q.mem_req;
  assign mem_we_out      = q_q.mem_we;
  assign mem_byte_out    = q_q.mem_byte;
  assign mem_addr_out    = q_q.mem_addr;
  assign mem_wdata_out   = q_q.mem_wdata;
  assign hold_ack_out    = q_q.hold_ack;
  assign sp_out          = stack_pointer_reg;
  assign fp_out          = frame_pointer_reg;
  assign gpr_rd_data_out = q_q.rd_data;
  assign flags_out       = q_q.flags;
  assign ext_res_out     = q_q.ext_res;

endmodule // sfx_exec

/* File: sfx_exec_props.sv */
`timescale 1ns/10ps

// ------------------------------------------------------------
// Port-level checker for the frame and swap sequencer
// ------------------------------------------------------------
module sfx_exec_props (
  input wire logic        core_clk_in,
  input wire logic        srst_in,
  input wire logic        clk_en_in,
  input wire logic        instr_valid_in,
  input wire logic [15:0] instr_in,
  input wire logic        mem_ready_in,
  input wire logic        flags_wr_en_in,
  input wire logic [15:0] ext_val_in,
  input wire logic [1:0]  ext_width_in,
  input wire logic [1:0]  ext_mode_in,
  input wire logic        instr_ready_out,
  input wire logic        busy_out,
  input wire logic        done_out,
  input wire logic        ilock_out,
  input wire logic        mem_req_out,
  input wire logic        mem_we_out,
  input wire logic        mem_byte_out,
  input wire logic [31:0] mem_addr_out,
  input wire logic [31:0] mem_wdata_out,
  input wire logic        hold_ack_out,
  input wire logic [31:0] sp_out,
  input wire logic [31:0] fp_out,
  input wire logic [3:0]  flags_out,
  input wire logic [31:0] ext_res_out
);
  // One clock domain, so clocking and disable are shared
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  // Taken frame build: link store and both pointers updated together
  a_enter_frame: assert property (
    instr_valid_in && instr_ready_out && clk_en_in && instr_in[15:8] == 8'h0f |=>
    mem_req_out && mem_we_out && mem_addr_out == $past(sp_out) - 32'h4 &&
    mem_wdata_out == $past(fp_out) && fp_out == $past(sp_out) - 32'h4 &&
    sp_out == $past(sp_out) - {22'h0, $past(instr_in[7:0]), 2'b00})
    else $error("frame build store or pointers wrong");
  // Taken frame release: reload read at old frame pointer
  a_leave_frame: assert property (
    instr_valid_in && instr_ready_out && clk_en_in && instr_in == 16'h9f9f |=>
    mem_req_out && !mem_we_out && mem_addr_out == $past(fp_out) &&
    sp_out == $past(fp_out) + 32'h4)
    else $error("frame release address or stack pointer wrong");
  // Swap read completing is followed at once by the byte write
  a_swap_pair: assert property (
    mem_req_out && !mem_we_out && mem_byte_out && mem_ready_in && clk_en_in |=>
    mem_req_out && mem_we_out && mem_byte_out)
    else $error("swap write does not follow swap read");
  a_swap_wdata: assert property (
    mem_req_out && mem_we_out && mem_byte_out |-> mem_wdata_out[31:8] == 24'h0)
    else $error("swap store carries more than one byte");
  // Bus is never handed over while an instruction owns it
  a_hold_refused: assert property (
    busy_out || mem_req_out |-> !hold_ack_out)
    else $error("bus hold granted inside an instruction");
  // Wait states stretch the access with the request held still
  a_access_holds: assert property (
    mem_req_out && !mem_ready_in && clk_en_in |=>
    mem_req_out && $stable(mem_addr_out) && $stable(mem_we_out))
    else $error("access changed before ready");
  // The final access is followed next cycle by completion or the interlock cycle
  a_end_follows: assert property (
    mem_req_out && mem_ready_in && clk_en_in && !(mem_byte_out && !mem_we_out) |=>
    !mem_req_out && (done_out || ilock_out))
    else $error("instruction did not end after last access");
  a_ilock_one: assert property (
    ilock_out && clk_en_in |=> done_out && !ilock_out)
    else $error("interlock is not exactly one cycle");
  // Flags move only by the explicit write port
  a_flags_kept: assert property (
    !$past(flags_wr_en_in) |-> $stable(flags_out))
    else $error("flags changed without a flag write");
  a_ext_zero: assert property (
    ext_mode_in == 2'h0 && ext_width_in == 2'h1 && clk_en_in |=>
    ext_res_out == {24'h0, $past(ext_val_in[7:0])})
    else $error("zero extension wrong");
  a_ext_ones: assert property (
    ext_mode_in == 2'h1 && ext_width_in == 2'h0 && clk_en_in |=>
    ext_res_out == {28'hfffffff, $past(ext_val_in[3:0])})
    else $error("ones extension wrong");
  a_ext_sign: assert property (
    ext_mode_in == 2'h2 && ext_width_in == 2'h3 && clk_en_in |=>
    ext_res_out == {{16{$past(ext_val_in[15])}}, $past(ext_val_in)})
    else $error("sign extension wrong");
endmodule // sfx_exec_props

bind sfx_exec sfx_exec_props u_props (.core_clk_in, .srst_in, .clk_en_in, .instr_valid_in,
  .instr_in, .mem_ready_in, .flags_wr_en_in, .ext_val_in, .ext_width_in, .ext_mode_in,
  .instr_ready_out, .busy_out, .done_out, .ilock_out, .mem_req_out, .mem_we_out,
  .mem_byte_out, .mem_addr_out, .mem_wdata_out, .hold_ack_out, .sp_out, .fp_out,
  .flags_out, .ext_res_out);

/* File: sfx_mem_model.sv */
`timescale 1ns/10ps

// ------------------------------------------------------------
// Memory side with ready wait states
// ------------------------------------------------------------
module sfx_mem_model (
  input  wire logic        clk_in,    // Core clock
  input  wire logic        req_in,    // Access request
  input  wire logic        we_in,     // Write access
  input  wire logic        byte_in,   // Byte access
  input  wire logic [31:0] addr_in,   // Address
  input  wire logic [31:0] wdata_in,  // Store data
  input  wire logic [3:0]  wait_in,   // Wait states per access
  output logic             ready_out, // Access completes
  output logic [31:0]      rdata_out  // Read data
);
  logic [31:0] mem [logic [31:0]]; // Sparse word store
  int          cnt = 0;            // Cycles of current access

  // Falling edge answer; read data garbled outside a completing read
  always @(negedge clk_in)
  begin
    if (!req_in)
      cnt = 0;
    else if (ready_out)
      cnt = 1;
    else
      cnt = cnt + 1;
    ready_out = req_in && (cnt > int'(wait_in));
    if (ready_out && we_in)
      mem[addr_in] = byte_in ? {mem[addr_in][31:8], wdata_in[7:0]} : wdata_in;
    if (ready_out && !we_in)
      rdata_out = byte_in ? {24'h0, mem[addr_in][7:0]} : mem[addr_in];
    else
      rdata_out = ~rdata_out;
  end
endmodule // sfx_mem_model

/* File: tb_stack_frame_exchange_exec.sv */
`timescale 1ns/10ps

module tb_stack_frame_exchange_exec;
  // ------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------
  logic        core_clk_in = 1'b0;
  logic        srst_in = 1'b1;
  logic        clk_en_in, instr_valid_in, next_sp_access_in, next_type_a_in;
  logic        mem_ready_in, hold_req_in, gpr_wr_en_in, flags_wr_en_in;
  logic [15:0] instr_in, next_reads_gpr_in, ext_val_in;
  logic [31:0] mem_rdata_in, gpr_wr_data_in, mem_addr_out, mem_wdata_out;
  logic [3:0]  gpr_wr_idx_in, gpr_rd_idx_in, flags_in, flags_out, wait_cnt;
  logic [1:0]  ext_width_in, ext_mode_in;
  logic        instr_ready_out, busy_out, done_out, ilock_out, hold_ack_out;
  logic        mem_req_out, mem_we_out, mem_byte_out;
  logic [31:0] sp_out, fp_out, gpr_rd_data_out, ext_res_out, rd;
  int          error_cnt = 0;
  int          check_count = 0;
  int          cyc;

  always #50 core_clk_in = ~core_clk_in;

  sfx_exec dut (.*);
  sfx_mem_model u_mem (.clk_in(core_clk_in), .req_in(mem_req_out), .we_in(mem_we_out),
    .byte_in(mem_byte_out), .addr_in(mem_addr_out), .wdata_in(mem_wdata_out),
    .wait_in(wait_cnt), .ready_out(mem_ready_in), .rdata_out(mem_rdata_in));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out;
    if (error_cnt == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Preload only lands while idle
  task automatic set_reg(input logic [3:0] idx, input logic [31:0] val);
    gpr_wr_en_in = 1'b1;
    gpr_wr_idx_in = idx;
    gpr_wr_data_in = val;
    @(negedge core_clk_in);
    gpr_wr_en_in = 1'b0;
    @(negedge core_clk_in);
  endtask

  // Peek output is registered, so give it two full cycles
  task automatic peek(input logic [3:0] idx, output logic [31:0] val);
    gpr_rd_idx_in = idx;
    repeat (2) @(negedge core_clk_in);
    val = gpr_rd_data_out;
  endtask

  // Offer one instruction; count cycles until its completion pulse
  task automatic run(input logic [15:0] op, output int n);
    instr_in = op;
    instr_valid_in = 1'b1;
    @(negedge core_clk_in);
    instr_valid_in = 1'b0;
    n = 1;
    while (done_out !== 1'b1 && n < 100)
    begin
      @(negedge core_clk_in);
      n++;
    end
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic s_frame;
    flags_in = 4'ha;
    flags_wr_en_in = 1'b1;
    @(negedge core_clk_in);
    flags_wr_en_in = 1'b0;
    set_reg(4'hf, 32'h7fff_fff8);
    set_reg(4'he, 32'h8000_0000);
    check("sp alias", sp_out, 32'h7fff_fff8);
    wait_cnt = 4'h2;
    next_sp_access_in = 1'b1;
    run(16'h0f03, cyc);
    check("enter cycles", cyc, 32'h5);
    check("enter sp", sp_out, 32'h7fff_ffec);
    check("enter fp", fp_out, 32'h7fff_fff4);
    check("enter link", u_mem.mem[32'h7fff_fff4], 32'h8000_0000);
    // Largest frame, two-register follower interlocks
    next_sp_access_in = 1'b0;
    next_type_a_in = 1'b1;
    wait_cnt = 4'h0;
    run(16'h0fff, cyc);
    check("enter max cycles", cyc, 32'h3);
    check("enter max sp", sp_out, 32'h7fff_fbf0);
    next_type_a_in = 1'b0;
    next_reads_gpr_in = 16'h4000;
    wait_cnt = 4'h1;
    run(16'h9f9f, cyc);
    check("leave cycles", cyc, 32'h4);
    check("leave sp", sp_out, 32'h7fff_ffec);
    check("leave fp", fp_out, 32'h7fff_fff4);
    next_reads_gpr_in = 16'h0000;
    wait_cnt = 4'h0;
    run(16'h9f9f, cyc);
    check("leave plain cycles", cyc, 32'h2);
    check("leave plain fp", fp_out, 32'h8000_0000);
  endtask

  // Swap with a pending hold request and stretched accesses
  task automatic s_swap;
    set_reg(4'h1, 32'h0000_0100);
    set_reg(4'h0, 32'h1234_56ab);
    u_mem.mem[32'h0000_0100] = 32'hcafe_0077;
    hold_req_in = 1'b1;
    wait_cnt = 4'h1;
    run(16'h8a10, cyc);
    check("swap cycles", cyc, 32'h5);
    check("swap memory", u_mem.mem[32'h0000_0100], 32'hcafe_00ab);
    peek(4'h0, rd);
    check("swap dest", rd, 32'h0000_0077);
    check("hold after swap", hold_ack_out, 32'h1);
    hold_req_in = 1'b0;
    repeat (2) @(negedge core_clk_in);
  endtask

  // Unknown opcode is dropped with the port staying ready
  task automatic s_refuse;
    run(16'h0000, cyc);
    check("drop cycles", cyc, 32'h64);
    check("drop ready", instr_ready_out, 32'h1);
    check("drop busy", busy_out, 32'h0);
    // Enable low freezes the extension register too
    clk_en_in = 1'b0;
    ext_val_in = 16'h0005;
    @(negedge core_clk_in);
    check("frozen ext", ext_res_out, 32'h0);
    clk_en_in = 1'b1;
    @(negedge core_clk_in);
    check("thawed ext", ext_res_out, 32'h5);
  endtask

  task automatic s_extend;
    logic [51:0] tab [9] = '{ {2'h0, 2'h0, 16'hfffa, 32'h0000_000a},
      {2'h0, 2'h1, 16'hff85, 32'h0000_0085}, {2'h2, 2'h3, 16'h8001, 32'hffff_8001},
      {2'h1, 2'h0, 16'h0000, 32'hffff_fff0}, {2'h2, 2'h1, 16'h0080, 32'hffff_ff80},
      {2'h2, 2'h2, 16'h01ff, 32'h0000_01ff}, {2'h0, 2'h3, 16'h8001, 32'h0000_8001},
      {2'h3, 2'h3, 16'h8001, 32'h0000_8001}, {2'h1, 2'h1, 16'h0012, 32'hffff_ff12} };
    foreach (tab[i])
    begin
      {ext_mode_in, ext_width_in, ext_val_in} = tab[i][51:32];
      @(negedge core_clk_in);
      check("extension", ext_res_out, tab[i][31:0]);
    end
  endtask

  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial
  begin
    {clk_en_in, instr_valid_in, next_sp_access_in, next_type_a_in} = 4'h8;
    {hold_req_in, gpr_wr_en_in, flags_wr_en_in} = 3'h0;
    {instr_in, next_reads_gpr_in, ext_val_in} = 48'h0;
    {gpr_wr_idx_in, gpr_rd_idx_in, flags_in, wait_cnt} = 16'h0;
    {gpr_wr_data_in, ext_width_in, ext_mode_in} = 36'h0;
    repeat (10) @(negedge core_clk_in);
    srst_in = 1'b0;
    check("reset ready", instr_ready_out, 32'h1);
    check("reset sp", sp_out, 32'h0);
    s_frame();
    s_swap();
    s_refuse();
    s_extend();
    check("flags kept", flags_out, 32'ha);
    close_out();
  end

  initial
  begin
    #(5000 * 100);
    error_cnt++;
    close_out();
  end
endmodule // tb_stack_frame_exchange_exec
